// [rtl/adc_sequence_controller.sv]
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
// Behaviour
// - Single-shot runs one sequence, then clears go and sets the flag.
// - Loop mode repeats the sequence; started by go or a trigger.
// - In loop mode the flag is raised at the programmed word rate.
// - Single-channel mode converts one channel of the chosen group.
// - Multi mode 00 samples and converts A then B.
// - Multi mode 01 samples and converts A, B, C, D in turn.
// - Multi mode 10 samples A and B together, converts each.
// - Multi mode 11 pairs A/B, then C/D, each sampled together.
// - Single-channel mode values 00 to 11 pick group A to D.
// - Loop bit at control 0 bit 5, mode field at bits 3:2.
// - Result bytes show the buffer entry at the pointer field.
// - Four-entry circular buffer with empty and overflow bits.
// - Each conversion yields a 10-bit value.
// - Reset clears registers, turns off and aborts conversion.
// - Only the internal RC conversion clock runs during sleep.
// - Groups A{0,4,8} B{1,5} C{2,6} D{3,7}, two-bit select for A, one-bit for B to D.
// - Each converter pin is analog or digital per select registers.
// - Reference field picks supply rails or external references.
module adc_sequence_controller (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [4:0] trig_events,
   input wire logic sleep_mode,
   output adc_seq_pkg::fe_req_t fe_req,
   input wire adc_seq_pkg::fe_rsp_t fe_rsp,
   output logic [1:0] ref_config,
   output logic [8:0] analog_pin_en,
   output logic converter_on,
   output logic conversion_irq_flag
);

   ////////////////////////////////////////////////////////////////////
   logic [7:0] ctl0_q, ctl0_d, ctl2_q, ctl2_d, ctl3_q, ctl3_d;
   logic [7:0] chs_q, chs_d, analog_pin_select_0_q, analog_pin_select_0_d, rdata_q, rdata_d;
   logic analog_pin_select_1_q, analog_pin_select_1_d, fifo_q, fifo_d, ovfl_q, ovfl_d;
   logic irq_q, irq_d;
   logic [1:0] ref_q, ref_d, ptr_q, ptr_d, wp_q, wp_d;
   logic [2:0] cnt_q, cnt_d;
   logic [9:0] buf_q [adc_seq_pkg::BUF_DEPTH];
   logic [9:0] buf_d [adc_seq_pkg::BUF_DEPTH];
   adc_seq_pkg::state_t state_q, state_d;
   logic [1:0] step_q, step_d;
   logic [6:0] div_q, div_d, div_max;
   logic [3:0] acq_q, acq_d;
   logic [2:0] rate_q, rate_d, rate_max;
   adc_seq_pkg::fe_req_t fe_q, fe_d;
   logic store_ev, irq_ev, tick, rc_sel, wr_ctl0, start, abort;
   logic loop_m, multi, sim, on, need_samp;
   logic [1:0] mode, last_step, group, nstep;
   logic [9:0] cur;

   assign loop_m = ctl0_q[adc_seq_pkg::C0_LOOP];
   assign multi = ctl0_q[adc_seq_pkg::C0_MULTI];
   assign mode = ctl0_q[adc_seq_pkg::C0_MODE_HI:adc_seq_pkg::C0_MODE_LO];
   assign on = ctl0_q[adc_seq_pkg::C0_ON];
   assign sim = multi & mode[1];
   // Two steps for 00/10, four for 01/11, one in single mode
   assign last_step = multi ? {mode[0], 1'b1} : 2'h0;
   assign group = multi ? step_q : mode;
   assign nstep = 2'(step_q + 2'h1);
   // Simultaneous pairs sample once per even step only
   assign need_samp = !sim || !nstep[0];

   // Channel number from group and its select field
   function automatic logic [3:0] chan_of(input logic [1:0] g,
                                          input logic [7:0] chs);
      logic [1:0] sel;
      sel = 2'h0;
      if (g == 2'h0) begin
         sel = (chs[1:0] == 2'h3) ? 2'h0 : chs[1:0];
      end else if (g == 2'h1) begin
         sel = {1'b0, chs[4]};
      end else if (g == 2'h2) begin
         sel = {1'b0, chs[2]};
      end else begin
         sel = {1'b0, chs[6]};
      end
      return {sel, g};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Conversion clock
   assign rc_sel = ctl2_q[adc_seq_pkg::C2_CLK_LO+1:adc_seq_pkg::C2_CLK_LO]
                   == 2'h3;
   always_comb begin
      div_max = adc_seq_pkg::RC_DIV;
      case (ctl2_q[adc_seq_pkg::C2_CLK_HI:adc_seq_pkg::C2_CLK_LO])
         3'h0: div_max = adc_seq_pkg::DIV_2;
         3'h1: div_max = adc_seq_pkg::DIV_8;
         3'h2: div_max = adc_seq_pkg::DIV_32;
         3'h4: div_max = adc_seq_pkg::DIV_4;
         3'h5: div_max = adc_seq_pkg::DIV_16;
         3'h6: div_max = adc_seq_pkg::DIV_64;
         default: div_max = adc_seq_pkg::RC_DIV;
      endcase
   end
   // System-derived clock stalls in sleep; the RC clock keeps going
   assign tick = (div_q == div_max) && (!sleep_mode || rc_sel);

   always_comb begin
      case (ctl3_q[adc_seq_pkg::C3_RATE_HI:adc_seq_pkg::C3_RATE_LO])
         2'h0: rate_max = adc_seq_pkg::RATE_1;
         2'h1: rate_max = adc_seq_pkg::RATE_2;
         default: rate_max = adc_seq_pkg::RATE_4;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   assign wr_ctl0 = reg_wr && (reg_addr == adc_seq_pkg::IDX_CTL0);
   assign start = (state_q == adc_seq_pkg::ST_IDLE) && on
      && ((wr_ctl0 && reg_wdata[adc_seq_pkg::C0_GO]
           && reg_wdata[adc_seq_pkg::C0_ON])
          || (loop_m && |(trig_events & ctl3_q[adc_seq_pkg::C3_TRIG_HI:
                                               adc_seq_pkg::C3_TRIG_LO])));
   // Clearing go or on stops the sequence at once
   assign abort = !on || (wr_ctl0 && (!reg_wdata[adc_seq_pkg::C0_GO]
                                      || !reg_wdata[adc_seq_pkg::C0_ON]));

   always_comb begin
      state_d = state_q;
      step_d = step_q;
      acq_d = acq_q;
      rate_d = rate_q;
      div_d = (tick || state_q == adc_seq_pkg::ST_IDLE) ? 7'h00
              : 7'(div_q + 7'h01);
      if (sleep_mode && !rc_sel) begin
         div_d = div_q;
      end
      fe_d = fe_q;
      fe_d.sample = 1'b0;
      fe_d.convert = 1'b0;
      store_ev = 1'b0;
      irq_ev = 1'b0;
      case (state_q)
         adc_seq_pkg::ST_IDLE: begin
            if (start) begin
               state_d = adc_seq_pkg::ST_ACQ;
               step_d = 2'h0;
               acq_d = 4'h0;
               rate_d = 3'h0;
            end
         end
         adc_seq_pkg::ST_ACQ: begin
            if (tick) begin
               if (acq_q == ctl2_q[adc_seq_pkg::C2_ACQ_HI:
                                   adc_seq_pkg::C2_ACQ_LO]) begin
                  state_d = adc_seq_pkg::ST_SAMP;
               end else begin
                  acq_d = 4'(acq_q + 4'h1);
               end
            end
         end
         adc_seq_pkg::ST_SAMP: begin
            if (tick) begin
               fe_d.sample = 1'b1;
               if (sim) begin
                  fe_d.chan_a = chan_of({step_q[1], 1'b0}, chs_q);
                  fe_d.chan_b = chan_of({step_q[1], 1'b1}, chs_q);
               end else begin
                  fe_d.chan_a = chan_of(group, chs_q);
                  fe_d.chan_b = fe_q.chan_b;
               end
               state_d = adc_seq_pkg::ST_CONV;
            end
         end
         adc_seq_pkg::ST_CONV: begin
            if (tick) begin
               fe_d.convert = 1'b1;
               fe_d.conv_b = sim && step_q[0];
               state_d = adc_seq_pkg::ST_WAIT;
            end
         end
         adc_seq_pkg::ST_WAIT: begin
            if (fe_rsp.done) begin
               store_ev = 1'b1;
               rate_d = 3'(rate_q + 3'h1);
               if (loop_m && rate_d == rate_max) begin
                  irq_ev = 1'b1;
                  rate_d = 3'h0;
               end
               if (step_q != last_step) begin
                  step_d = nstep;
                  acq_d = 4'h0;
                  state_d = need_samp ? adc_seq_pkg::ST_ACQ
                            : adc_seq_pkg::ST_CONV;
               end else if (loop_m) begin
                  step_d = 2'h0;
                  acq_d = 4'h0;
                  state_d = adc_seq_pkg::ST_ACQ;
               end else begin
                  irq_ev = 1'b1;
                  state_d = adc_seq_pkg::ST_IDLE;
               end
            end
         end
         default: state_d = adc_seq_pkg::ST_IDLE;
      endcase
      if (abort && state_q != adc_seq_pkg::ST_IDLE) begin
         state_d = adc_seq_pkg::ST_IDLE;
         store_ev = 1'b0;
         irq_ev = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= adc_seq_pkg::ST_IDLE;
         step_q <= 2'h0;
         acq_q <= 4'h0;
         rate_q <= 3'h0;
         div_q <= 7'h00;
         fe_q <= '0;
      end else begin
         state_q <= state_d;
         step_q <= step_d;
         acq_q <= acq_d;
         rate_q <= rate_d;
         div_q <= div_d;
         fe_q <= fe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Registers and result buffer
   assign cur = buf_q[ptr_q];
   always_comb begin
      ctl0_d = ctl0_q;
      ctl2_d = ctl2_q;
      ctl3_d = ctl3_q;
      chs_d = chs_q;
      analog_pin_select_0_d = analog_pin_select_0_q;
      analog_pin_select_1_d = analog_pin_select_1_q;
      fifo_d = fifo_q;
      ref_d = ref_q;
      ptr_d = ptr_q;
      ovfl_d = ovfl_q;
      irq_d = irq_q;
      cnt_d = cnt_q;
      wp_d = wp_q;
      buf_d = buf_q;
      rdata_d = 8'h00;
      if (reg_wr) begin
         if (reg_addr == adc_seq_pkg::IDX_CTL0) begin
            ctl0_d = reg_wdata & adc_seq_pkg::CTL0_STORE_MASK;
         end else if (reg_addr == adc_seq_pkg::IDX_CTL1) begin
            ref_d = reg_wdata[adc_seq_pkg::C1_REF_HI:
                              adc_seq_pkg::C1_REF_LO];
            fifo_d = reg_wdata[adc_seq_pkg::C1_FIFO];
            ptr_d = reg_wdata[adc_seq_pkg::C1_PTR_HI:
                              adc_seq_pkg::C1_PTR_LO];
            ovfl_d = ovfl_q & reg_wdata[adc_seq_pkg::C1_OVFL];
         end else if (reg_addr == adc_seq_pkg::IDX_CTL2) begin
            ctl2_d = reg_wdata;
         end else if (reg_addr == adc_seq_pkg::IDX_CTL3) begin
            ctl3_d = reg_wdata;
         end else if (reg_addr == adc_seq_pkg::IDX_CHS) begin
            chs_d = reg_wdata;
         end else if (reg_addr == adc_seq_pkg::IDX_ANALOG_PIN_SELECT_0) begin
            analog_pin_select_0_d = reg_wdata;
         end else if (reg_addr == adc_seq_pkg::IDX_ANALOG_PIN_SELECT_1) begin
            analog_pin_select_1_d = reg_wdata[0];
         end else if (reg_addr == adc_seq_pkg::IDX_STATUS) begin
            irq_d = irq_q & reg_wdata[adc_seq_pkg::ST_IRQ];
         end
      end
      if (reg_rd) begin
         if (reg_addr == adc_seq_pkg::IDX_RES_HI) begin
            rdata_d = ctl2_q[adc_seq_pkg::C2_FMT] ? {6'h00, cur[9:8]}
                      : cur[9:2];
         end else if (reg_addr == adc_seq_pkg::IDX_RES_LO) begin
            rdata_d = ctl2_q[adc_seq_pkg::C2_FMT] ? cur[7:0]
                      : {cur[1:0], 6'h00};
            // Low-byte read pops the entry so the buffer can drain
            if (cnt_q != 3'h0) begin
               cnt_d = 3'(cnt_q - 3'h1);
            end
            if (fifo_q) begin
               ptr_d = 2'(ptr_q + 2'h1);
            end
         end else if (reg_addr == adc_seq_pkg::IDX_CTL0) begin
            rdata_d = ctl0_q;
            rdata_d[adc_seq_pkg::C0_GO] =
               (state_q != adc_seq_pkg::ST_IDLE);
         end else if (reg_addr == adc_seq_pkg::IDX_CTL1) begin
            rdata_d = {ref_q, 1'b0, fifo_q, cnt_q == 3'h0, ovfl_q, ptr_q};
         end else if (reg_addr == adc_seq_pkg::IDX_CTL2) begin
            rdata_d = ctl2_q;
         end else if (reg_addr == adc_seq_pkg::IDX_CTL3) begin
            rdata_d = ctl3_q;
         end else if (reg_addr == adc_seq_pkg::IDX_CHS) begin
            rdata_d = chs_q;
         end else if (reg_addr == adc_seq_pkg::IDX_ANALOG_PIN_SELECT_0) begin
            rdata_d = analog_pin_select_0_q;
         end else if (reg_addr == adc_seq_pkg::IDX_ANALOG_PIN_SELECT_1) begin
            rdata_d = {7'h00, analog_pin_select_1_q};
         end else if (reg_addr == adc_seq_pkg::IDX_STATUS) begin
            rdata_d = {7'h00, irq_q};
         end
      end
      // Hardware sets win over a software clear in the same cycle
      if (store_ev) begin
         buf_d[wp_q] = fe_rsp.data;
         wp_d = 2'(wp_q + 2'h1);
         if (cnt_q == adc_seq_pkg::BUF_FULL) begin
            ovfl_d = 1'b1;
         end else begin
            cnt_d = 3'(cnt_d + 3'h1);
         end
      end
      if (irq_ev) begin
         irq_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctl0_q <= 8'h00;
         ctl2_q <= 8'h00;
         ctl3_q <= 8'h00;
         chs_q <= 8'h00;
         analog_pin_select_0_q <= 8'h00;
         analog_pin_select_1_q <= 1'b0;
         fifo_q <= 1'b0;
         ref_q <= 2'h0;
         ptr_q <= 2'h0;
         ovfl_q <= 1'b0;
         irq_q <= 1'b0;
         cnt_q <= 3'h0;
         wp_q <= 2'h0;
         rdata_q <= 8'h00;
         for (int i = 0; i < adc_seq_pkg::BUF_DEPTH; i++) begin
            buf_q[i] <= 10'h000;
         end
      end else begin
         ctl0_q <= ctl0_d;
         ctl2_q <= ctl2_d;
         ctl3_q <= ctl3_d;
         chs_q <= chs_d;
         analog_pin_select_0_q <= analog_pin_select_0_d;
         analog_pin_select_1_q <= analog_pin_select_1_d;
         fifo_q <= fifo_d;
         ref_q <= ref_d;
         ptr_q <= ptr_d;
         ovfl_q <= ovfl_d;
         irq_q <= irq_d;
         cnt_q <= cnt_d;
         wp_q <= wp_d;
         rdata_q <= rdata_d;
         buf_q <= buf_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign fe_req = fe_q;
   assign ref_config = ref_q;
   assign analog_pin_en = {analog_pin_select_1_q, analog_pin_select_0_q};
   assign converter_on = on;
   assign conversion_irq_flag = irq_q;

   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_last_done;
      state_q == adc_seq_pkg::ST_WAIT && fe_rsp.done && !abort
      && step_q == last_step;
   endsequence

   a_reset_clears: assert property (disable iff (1'b0)
      sys_rst |=> state_q == adc_seq_pkg::ST_IDLE && ctl0_q == 8'h00
                  && !irq_q && cnt_q == 3'h0)
      else $error("reset left state behind");
   a_single_done: assert property (s_last_done ##0 !loop_m
      |=> state_q == adc_seq_pkg::ST_IDLE && irq_q)
      else $error("single-shot end not flagged");
   a_loop_restart: assert property (s_last_done ##0 loop_m
      |=> state_q == adc_seq_pkg::ST_ACQ && step_q == 2'h0)
      else $error("loop did not restart");
   a_off_ignores: assert property (!on
      |=> state_q == adc_seq_pkg::ST_IDLE)
      else $error("busy while converter off");
   a_go_reads_busy: assert property (reg_rd
      && reg_addr == adc_seq_pkg::IDX_CTL0
      |=> reg_rdata[adc_seq_pkg::C0_GO]
          == ($past(state_q) != adc_seq_pkg::ST_IDLE))
      else $error("go bit does not show busy");
   a_store_fills: assert property (store_ev && !reg_rd
      |=> cnt_q != 3'h0 && buf_q[$past(wp_q)] == $past(fe_rsp.data))
      else $error("result not stored");
   a_ovfl_on_full: assert property (store_ev
      && cnt_q == adc_seq_pkg::BUF_FULL |=> ovfl_q)
      else $error("overflow not flagged");
   a_single_group: assert property (fe_q.sample && !multi
      |-> fe_q.chan_a[1:0] == mode)
      else $error("wrong group in single mode");
   a_sleep_stall: assert property (sleep_mode && !rc_sel
      && state_q != adc_seq_pkg::ST_IDLE && !abort |=> $stable(div_q))
      else $error("system clock ran in sleep");
endmodule

// [inc/adc_seq_pkg.sv]
package adc_seq_pkg;
   localparam int unsigned RES_W = 10;
   localparam int unsigned BUF_DEPTH = 4;
   localparam logic [2:0] BUF_FULL = 3'h4;
   // Register indices on the byte-wide register port
   localparam logic [3:0] IDX_RES_HI = 4'h0;
   localparam logic [3:0] IDX_RES_LO = 4'h1;
   localparam logic [3:0] IDX_CTL0 = 4'h2;
   localparam logic [3:0] IDX_CTL1 = 4'h3;
   localparam logic [3:0] IDX_CTL2 = 4'h4;
   localparam logic [3:0] IDX_CTL3 = 4'h5;
   localparam logic [3:0] IDX_CHS = 4'h6;
   localparam logic [3:0] IDX_ANALOG_PIN_SELECT_0 = 4'h7;
   localparam logic [3:0] IDX_ANALOG_PIN_SELECT_1 = 4'h8;
   localparam logic [3:0] IDX_STATUS = 4'h9;
   // Control 0 fields
   localparam int C0_LOOP = 5;
   localparam int C0_MULTI = 4;
   localparam int C0_MODE_HI = 3;
   localparam int C0_MODE_LO = 2;
   localparam int C0_GO = 1;
   localparam int C0_ON = 0;
   localparam logic [7:0] CTL0_STORE_MASK = 8'h3D;
   // Control 1 fields
   localparam int C1_REF_HI = 7;
   localparam int C1_REF_LO = 6;
   localparam int C1_FIFO = 4;
   localparam int C1_EMPTY = 3;
   localparam int C1_OVFL = 2;
   localparam int C1_PTR_HI = 1;
   localparam int C1_PTR_LO = 0;
   // Control 2 fields
   localparam int C2_FMT = 7;
   localparam int C2_ACQ_HI = 6;
   localparam int C2_ACQ_LO = 3;
   localparam int C2_CLK_HI = 2;
   localparam int C2_CLK_LO = 0;
   // Control 3 fields
   localparam int C3_RATE_HI = 7;
   localparam int C3_RATE_LO = 6;
   localparam int C3_TRIG_HI = 4;
   localparam int C3_TRIG_LO = 0;
   localparam int ST_IRQ = 0;
   // Conversion clock: system divisors and the internal RC period
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned RC_TAD_NS = 1000;
   localparam logic [6:0] RC_DIV =
      7'((RC_TAD_NS * CLK_MHZ) / 1000 - 1);
   localparam logic [6:0] DIV_2 = 7'h01;
   localparam logic [6:0] DIV_4 = 7'h03;
   localparam logic [6:0] DIV_8 = 7'h07;
   localparam logic [6:0] DIV_16 = 7'h0F;
   localparam logic [6:0] DIV_32 = 7'h1F;
   localparam logic [6:0] DIV_64 = 7'h3F;
   // Interrupt rate thresholds in stored words
   localparam logic [2:0] RATE_1 = 3'h1;
   localparam logic [2:0] RATE_2 = 3'h2;
   localparam logic [2:0] RATE_4 = 3'h4;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ACQ = 5'h02,
      ST_SAMP = 5'h04,
      ST_CONV = 5'h08,
      ST_WAIT = 5'h10
   } state_t;

   typedef struct packed {
      logic sample;
      logic [3:0] chan_a;
      logic [3:0] chan_b;
      logic convert;
      logic conv_b;
   } fe_req_t;

   typedef struct packed {
      logic done;
      logic [9:0] data;
   } fe_rsp_t;
endpackage

// [dv/fe_model.sv]
`timescale 1ns/100ps
module fe_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] lat,
   input wire adc_seq_pkg::fe_req_t fe_req,
   output adc_seq_pkg::fe_rsp_t fe_rsp
);
   logic [3:0] hold_a;
   logic [3:0] hold_b;
   logic [3:0] pick;
   logic [7:0] cnt;
   logic busy;
   logic [9:0] last;
   ////////////////////////////////////////////////////////////////////////
   // Result word is the channel number over a fixed code, so the bench
   // can tell which input was converted
   always @(posedge clk) begin
      fe_rsp.done <= 1'b0;
      // Data is not valid between results: show the inverse of the last
      fe_rsp.data <= ~last;
      if (sys_rst) begin
         busy <= 1'b0;
         last <= 10'h000;
      end else begin
         if (fe_req.sample) begin
            hold_a <= fe_req.chan_a;
            hold_b <= fe_req.chan_b;
         end
         if (fe_req.convert) begin
            busy <= 1'b1;
            cnt <= lat;
            pick <= fe_req.conv_b ? hold_b : hold_a;
         end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            fe_rsp.done <= 1'b1;
            fe_rsp.data <= {pick, 6'h15};
            last <= {pick, 6'h15};
         end else if (busy) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin \
   checks++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
   end \
end
module tb_top;
   typedef struct packed {
      logic [7:0] ctl0;
      logic [7:0] chs;
      logic [2:0] n;
      logic [15:0] chans;
   } row_t;
   logic clk, sys_rst, reg_wr, reg_rd, sleep_mode, converter_on;
   logic conversion_irq_flag;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, lat, v;
   logic [4:0] trig_events;
   logic [1:0] ref_config, wp;
   logic [8:0] analog_pin_en;
   adc_seq_pkg::fe_req_t fe_req;
   adc_seq_pkg::fe_rsp_t fe_rsp;
   row_t rows [8];
   int checks = 0, miscompares = 0, cycles = 0, done_cnt = 0, base;

   adc_sequence_controller i_dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .trig_events(trig_events),
      .sleep_mode(sleep_mode), .fe_req(fe_req), .fe_rsp(fe_rsp),
      .ref_config(ref_config), .analog_pin_en(analog_pin_en),
      .converter_on(converter_on),
      .conversion_irq_flag(conversion_irq_flag)
   );
   fe_model i_fe (
      .clk(clk), .sys_rst(sys_rst), .lat(lat), .fe_req(fe_req),
      .fe_rsp(fe_rsp)
   );
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // A hang ends the run instead of stalling the regression
   always @(posedge clk) begin
      cycles++;
      if (fe_rsp.done === 1'b1) done_cnt++;
      if (cycles == 30000) begin
         miscompares++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("Checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] q);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      q = reg_rdata;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e,
                      input string nm);
      logic [7:0] q;
      rd(a, q);
      `CHK(nm, e, q)
   endtask
   task automatic wait_flag(input int lim);
      int k;
      k = 0;
      while (conversion_irq_flag !== 1'b1 && k < lim) begin
         @(posedge clk);
         #1;
         k++;
      end
      `CHK("irq flag", 1'b1, conversion_irq_flag)
   endtask
   // Auto-pointer walks the entries just written; each low read pops one
   task automatic run_row(input row_t r);
      logic [9:0] d;
      wr(adc_seq_pkg::IDX_CHS, r.chs);
      wr(adc_seq_pkg::IDX_CTL0, r.ctl0);
      wr(adc_seq_pkg::IDX_CTL0, r.ctl0 | 8'h02);
      rdc(adc_seq_pkg::IDX_CTL0, r.ctl0 | 8'h02, "busy");
      wait_flag(2000);
      rdc(adc_seq_pkg::IDX_CTL0, r.ctl0, "go clear");
      wr(adc_seq_pkg::IDX_STATUS, 8'h00);
      wr(adc_seq_pkg::IDX_CTL1, {6'h04, wp});
      for (int i = 0; i < r.n; i++) begin
         d = {r.chans[i*4 +: 4], 6'h15};
         rdc(adc_seq_pkg::IDX_RES_HI, {6'h00, d[9:8]}, "hi");
         rdc(adc_seq_pkg::IDX_RES_LO, d[7:0], "lo");
         wp++;
      end
      rdc(adc_seq_pkg::IDX_CTL1, {6'h06, wp}, "empty");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      trig_events = 5'h00;
      sleep_mode = 1'b0;
      lat = 8'h03;
      wp = 2'h0;
      rows[0] = '{8'h01, 8'h02, 3'h1, 16'h0008};
      rows[1] = '{8'h05, 8'h10, 3'h1, 16'h0005};
      rows[2] = '{8'h09, 8'h04, 3'h1, 16'h0006};
      rows[3] = '{8'h0D, 8'h00, 3'h1, 16'h0003};
      rows[4] = '{8'h11, 8'h11, 3'h2, 16'h0054};
      rows[5] = '{8'h15, 8'h00, 3'h4, 16'h3210};
      rows[6] = '{8'h19, 8'h01, 3'h2, 16'h0014};
      rows[7] = '{8'h1D, 8'hFF, 3'h4, 16'h7650};
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(adc_seq_pkg::IDX_CTL1, 8'h08, "ctl1 reset");
      wr(adc_seq_pkg::IDX_CTL2, 8'h88);
      wr(adc_seq_pkg::IDX_ANALOG_PIN_SELECT_0, 8'hA5);
      wr(adc_seq_pkg::IDX_ANALOG_PIN_SELECT_1, 8'h01);
      wr(adc_seq_pkg::IDX_CTL1, 8'hC0);
      wr(4'hF, 8'hFF);
      repeat (2) @(posedge clk);
      #1;
      `CHK("pins", 9'h1A5, analog_pin_en)
      `CHK("ref", 2'h3, ref_config)
      rdc(4'hF, 8'h00, "unmapped");
      foreach (rows[i]) run_row(rows[i]);
      // Loop mode by trigger, slow front end, nothing read back
      lat <= 8'h28;
      wr(adc_seq_pkg::IDX_CTL3, 8'h41);
      wr(adc_seq_pkg::IDX_CTL0, 8'h21);
      base = done_cnt;
      trig_events <= 5'h01;
      @(posedge clk);
      trig_events <= 5'h00;
      rdc(adc_seq_pkg::IDX_CTL0, 8'h23, "trig start");
      wait_flag(2000);
      `CHK("words", 2, done_cnt - base)
      repeat (400) @(posedge clk);
      rd(adc_seq_pkg::IDX_CTL1, v);
      `CHK("ovfl", 1'b1, v[2])
      wr(adc_seq_pkg::IDX_CTL0, 8'h00);
      repeat (60) @(posedge clk);
      wr(adc_seq_pkg::IDX_CTL1, 8'h00);
      rd(adc_seq_pkg::IDX_CTL1, v);
      `CHK("ovfl clr", 1'b0, v[2])
      // Sleep: system-derived tick stalls, the RC tick carries on
      lat <= 8'h03;
      wr(adc_seq_pkg::IDX_CTL3, 8'h00);
      wr(adc_seq_pkg::IDX_STATUS, 8'h00);
      sleep_mode <= 1'b1;
      wr(adc_seq_pkg::IDX_CTL0, 8'h01);
      wr(adc_seq_pkg::IDX_CTL0, 8'h03);
      repeat (60) @(posedge clk);
      rdc(adc_seq_pkg::IDX_CTL0, 8'h03, "frozen");
      `CHK("no flag", 1'b0, conversion_irq_flag)
      wr(adc_seq_pkg::IDX_CTL2, 8'h8B);
      wait_flag(3000);
      // Reset in mid-conversion
      sleep_mode <= 1'b0;
      wr(adc_seq_pkg::IDX_CTL2, 8'h88);
      wr(adc_seq_pkg::IDX_STATUS, 8'h00);
      wr(adc_seq_pkg::IDX_CTL0, 8'h03);
      #1;
      `CHK("on", 1'b1, converter_on)
      repeat (3) @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      `CHK("off", 1'b0, converter_on)
      rdc(adc_seq_pkg::IDX_CTL0, 8'h00, "ctl0 reset");
      rdc(adc_seq_pkg::IDX_CTL1, 8'h08, "ctl1 reset");
      repeat (50) @(posedge clk);
      #1;
      `CHK("aborted", 1'b0, conversion_irq_flag)
      // Go beside on is refused while the stored on bit is still clear
      wr(adc_seq_pkg::IDX_CTL2, 8'h05);
      wr(adc_seq_pkg::IDX_CTL0, 8'h03);
      rdc(adc_seq_pkg::IDX_CTL0, 8'h01, "off start");
      wr(adc_seq_pkg::IDX_CTL0, 8'h03);
      // Divide-by-16 tick: three ticks must pass before any result
      repeat (40) @(posedge clk);
      #1;
      `CHK("slow tick", 1'b0, conversion_irq_flag)
      wait_flag(60);
      // Left-justified bytes, pointer held in place after reset
      rdc(adc_seq_pkg::IDX_RES_HI, 8'h05, "left hi");
      rdc(adc_seq_pkg::IDX_RES_LO, 8'h40, "left lo");
      print_verdict();
   end
endmodule
